// File: rtl/msl_pkg.sv
// Summary of operation
// - Drive config clock, capture bit per rising edge
// - After completion, release boot mode pins
// - Pull-ups enabled when pull-up pin low, until completion
// - Serial data output always actively driven
// - Init low while clearing; release, sample mode
// - Init line resets and enables memory
// - CRC mismatch drives init line low
// - Completion low while loading, released on success
// - Completion line selects memory while loading
// - Program low 300 ns restarts and clears
// - Lines held in reset until program high
// - Config clock from oscillator, rate from bitstream
// - Daisy chain forwards bits on falling edge
package msl_pkg;

   // -------------------------------------------------------------------
   // Timing.
   // -------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;    // Period of pclk.
   localparam int unsigned PROG_MIN_NS   = 300;  // Least low time on the program input.
   localparam int unsigned PROG_MIN_CYC  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CLEAR_CYC     = 64;   // Cycles spent clearing configuration memory.
   localparam int unsigned START_HALF    = 8;    // Half period of the slow start clock, in pclk cycles.
   localparam int unsigned MIN_HALF      = 4;    // Fastest half period that the sampling can serve.
   localparam int unsigned RATE_BITS     = 8;    // Leading bitstream bits that carry the rate option.

   // -------------------------------------------------------------------
   // Register map, byte addresses.
   // -------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] BITCNT_OFF = 8'h08;
   localparam logic [7:0] RATE_OFF   = 8'h0C;

   // Control fields and reset values.
   localparam int unsigned CTRL_RELOAD_BIT  = 0;  // Write 1 to request a reload.
   localparam int unsigned CTRL_FORWARD_BIT = 1;  // Enables daisy-chain forwarding.
   localparam logic        CTRL_FORWARD_RST = 1'b1;

   // Status fields.
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_MODE_LSB  = 3;
   localparam int unsigned ST_CRC_BIT   = 6;
   localparam int unsigned ST_MODE_BIT  = 7;
   localparam int unsigned ST_DONE_BIT  = 8;
   localparam int unsigned ST_PULL_BIT  = 9;

   localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;

   // Loader states, Gray coded along the normal path.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_CLEAR = 3'h1,
      ST_WAIT  = 3'h3,
      ST_LOAD  = 3'h2,
      ST_DONE  = 3'h6,
      ST_ERROR = 3'h7
   } load_state_t;

   // Inputs from the pins, all asynchronous to pclk.
   typedef struct packed {
      logic [2:0] mode;               // Boot mode pins.
      logic       pullup_disable_pin; // Pull-up control pin.
      logic       data;               // Serial data from the memory.
      logic       init;               // Level on the shared init line.
      logic       done;               // Level on the completion line.
      logic       reload_request_n;   // Program input, active low.
   } pin_in_t;

   // The program input resets to its active level, so no load starts before the real pin is seen.
   localparam pin_in_t PIN_IN_RST = '{mode: 3'h0, pullup_disable_pin: 1'b0, data: 1'b0,
                                      init: 1'b0, done: 1'b0, reload_request_n: 1'b0};

   // Outputs toward the pins.
   typedef struct packed {
      logic config_clock_out; // Configuration clock to the memory.
      logic data_out;         // Serial data toward the next device.
      logic init_out;         // Init line value, always low.
      logic init_oe_n;        // Low while the init line is pulled low.
      logic done_out;         // Completion line value, always low.
      logic done_oe_n;        // Low while the completion line is pulled low.
      logic pullup_enable;    // Pull-ups on user pins.
      logic mode_released;    // Mode and pull-up pins free for user use.
   } pin_out_t;

endpackage

// File: rtl/crc_serial.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------------
// Bit-serial CRC accumulator, MSB first.
// -----------------------------------------------------------------------
module crc_serial #(
   parameter int unsigned     W    = 16,
   parameter logic [W-1:0]    POLY = 16'h1021,
   parameter logic [W-1:0]    SEED = 16'hFFFF
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic         clear,
   input  wire logic         bit_valid,
   input  wire logic         bit_in,
   output logic [W-1:0]      crc
);
   // The shift path needs at least two remainder bits.
   if (W < 2) begin : g_bad_width
      $error("crc_serial: remainder width below two bits");
   end

   logic [W-1:0] crc_ff;   // Running remainder.
   logic [W-1:0] nxt_crc;  // Remainder after one more bit.
   wire          fb = crc_ff[W-1] ^ bit_in;  // Feedback term.

   assign nxt_crc = {crc_ff[W-2:0], 1'b0} ^ (fb ? POLY : '0);
   assign crc     = crc_ff;

   // Clear takes priority, so a new load never inherits the old remainder.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_ff <= SEED;
      end else if (ce) begin
         if (clear) begin
            crc_ff <= SEED;
         end else if (bit_valid) begin
            crc_ff <= nxt_crc;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/master_serial_config_loader.sv
`timescale 1ns/10ps
`default_nettype none
module master_serial_config_loader #(
   parameter int unsigned  BITS_TOTAL = 1024,      // Bitstream length, rate and CRC included.
   parameter int unsigned  CRC_W      = 16,        // CRC width.
   parameter logic [15:0]  CRC_POLY   = 16'h1021,  // CRC polynomial.
   parameter logic [15:0]  CRC_SEED   = 16'hFFFF   // CRC start value.
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            ce,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire msl_pkg::pin_in_t  pins_in,
   output var msl_pkg::pin_out_t  pins_out
);
   import msl_pkg::*;

   // Refuse at elaboration what the fixed 16-bit check and 24-bit counter cannot serve.
   if (CRC_W != 16 || BITS_TOTAL <= RATE_BITS + CRC_W || BITS_TOTAL >= 32'h00FF_FFFF) begin : g_bad_params
      $error("master_serial_config_loader: unsupported CRC width or bitstream length");
   end

   // -------------------------------------------------------------------
   // Pin synchronisers.
   // -------------------------------------------------------------------
   pin_in_t sync1_ff;  // First stage, read only by the second.
   pin_in_t sync2_ff;  // Stable copy of the pins.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= PIN_IN_RST;
         sync2_ff <= PIN_IN_RST;
      end else if (ce) begin
         sync1_ff <= pins_in;
         sync2_ff <= sync1_ff;
      end
   end

   // -------------------------------------------------------------------
   // State and counters.
   // -------------------------------------------------------------------
   load_state_t state_ff, nxt_state;  // Loader state.
   logic [7:0]  prog_cnt_ff;          // Cycles the program input has been low.
   logic [7:0]  clear_cnt_ff;         // Cycles spent clearing.
   logic [23:0] bit_cnt_ff;           // Bits taken in this load.
   logic [7:0]  rate_sr_ff;           // Rate option as it shifts in.
   logic [7:0]  half_ff;              // Current half period of the config clock.
   logic [7:0]  div_cnt_ff;           // Divider count within a half period.
   logic        cfg_clk_ff;           // Config clock level.
   logic        dout_ff;              // Serial data output level.
   logic [15:0] crc_rx_ff;            // Received check value.
   logic [2:0]  mode_ff;              // Mode sampled when init rose.
   logic        crc_err_ff;           // CRC mismatch seen.
   logic        mode_err_ff;          // Mode other than master serial.
   logic        forward_en_ff;        // Daisy-chain forwarding allowed.
   logic        soft_reload_ff;       // Software reload request pulse.
   pin_out_t    pins_out_ff;          // Registered pin outputs.
   logic [15:0] crc_calc;             // Remainder from the accumulator.

   // Program input decoding: a low that lasts the least time is a restart.
   wire prog_low  = !sync2_ff.reload_request_n;
   wire prog_seen = (prog_cnt_ff == 8'(PROG_MIN_CYC));
   wire restart   = prog_seen || soft_reload_ff;

   // The config clock runs while loading, and after it while forwarding.
   wire clk_run   = (state_ff == ST_LOAD) || (state_ff == ST_DONE && forward_en_ff);
   wire half_tick = clk_run && (div_cnt_ff == half_ff - 8'h01);
   wire rise      = half_tick && !cfg_clk_ff;
   wire fall      = half_tick && cfg_clk_ff;

   // Bit position decoding.
   wire load_bit  = rise && (state_ff == ST_LOAD);
   wire in_rate   = (bit_cnt_ff < 24'(RATE_BITS));
   wire in_body   = (bit_cnt_ff < 24'(BITS_TOTAL - CRC_W));
   wire last_bit  = (bit_cnt_ff == 24'(BITS_TOTAL - 1));
   wire rate_last = (bit_cnt_ff == 24'(RATE_BITS - 1));
   wire [15:0] crc_full = {crc_rx_ff[14:0], sync2_ff.data};
   wire crc_ok    = (crc_full == crc_calc);
   wire [7:0] rate_new = {rate_sr_ff[6:0], sync2_ff.data};
   wire [7:0] rate_half = (rate_new < 8'(MIN_HALF)) ? 8'(MIN_HALF) : rate_new;

   crc_serial #(
      .W    (16),
      .POLY (CRC_POLY),
      .SEED (CRC_SEED)
   ) u_crc (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .clear     (state_ff == ST_CLEAR),
      .bit_valid (load_bit && in_body),
      .bit_in    (sync2_ff.data),
      .crc       (crc_calc)
   );

   // -------------------------------------------------------------------
   // Next state.
   // -------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (restart) begin
         nxt_state = ST_IDLE;
      end else begin
         unique case (state_ff)
            // Leave reset only with the program input high.
            ST_IDLE: begin
               if (!prog_low) nxt_state = ST_CLEAR;
            end
            ST_CLEAR: begin
               if (clear_cnt_ff == 8'(CLEAR_CYC - 1)) nxt_state = ST_WAIT;
            end
            // The memory may keep init low until it is ready.
            ST_WAIT: begin
               if (sync2_ff.init) begin
                  nxt_state = (sync2_ff.mode == MODE_MASTER_SERIAL) ? ST_LOAD : ST_ERROR;
               end
            end
            ST_LOAD: begin
               if (load_bit && last_bit) nxt_state = crc_ok ? ST_DONE : ST_ERROR;
            end
            ST_DONE:  nxt_state = ST_DONE;
            ST_ERROR: nxt_state = ST_ERROR;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Loader registers.
   // -------------------------------------------------------------------
   // State, restart filter and clearing timer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= ST_IDLE;
         prog_cnt_ff  <= 8'h00;
         clear_cnt_ff <= 8'h00;
      end else if (ce) begin
         state_ff     <= nxt_state;
         prog_cnt_ff  <= !prog_low ? 8'h00 : (prog_seen ? prog_cnt_ff : prog_cnt_ff + 8'h01);
         clear_cnt_ff <= (state_ff == ST_CLEAR) ? clear_cnt_ff + 8'h01 : 8'h00;
      end
   end

   // Config clock divider; starts at START_HALF and takes the rate option's half period once the option is in.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_ff <= 8'h00;
         cfg_clk_ff <= 1'b0;
         half_ff    <= 8'(START_HALF);
      end else if (ce) begin
         div_cnt_ff <= (!clk_run || half_tick) ? 8'h00 : div_cnt_ff + 8'h01;
         if (half_tick) cfg_clk_ff <= !cfg_clk_ff;
         else if (!clk_run) cfg_clk_ff <= 1'b0;
         if (state_ff == ST_CLEAR) half_ff <= 8'(START_HALF);
         else if (load_bit && rate_last) half_ff <= rate_half;
      end
   end

   // Bit capture on each rising config clock edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_ff <= 24'h000000;
         rate_sr_ff <= 8'h00;
         crc_rx_ff  <= 16'h0000;
      end else if (ce) begin
         if (state_ff == ST_CLEAR) begin
            bit_cnt_ff <= 24'h000000;
         end else if (load_bit) begin
            bit_cnt_ff <= bit_cnt_ff + 24'h000001;
            if (in_rate) rate_sr_ff <= rate_new;
            if (!in_body) crc_rx_ff <= crc_full;
         end
      end
   end

   // Data output: held high while loading, then forwards on falling edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_ff <= 1'b1;
      end else if (ce) begin
         if (state_ff != ST_DONE) dout_ff <= 1'b1;
         else if (fall) dout_ff <= sync2_ff.data;
      end
   end

   // Mode capture and error flags; the clearing state after a restart clears both error flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff     <= 3'h0;
         crc_err_ff  <= 1'b0;
         mode_err_ff <= 1'b0;
      end else if (ce) begin
         if (state_ff == ST_CLEAR) begin
            crc_err_ff  <= 1'b0;
            mode_err_ff <= 1'b0;
         end else if (state_ff == ST_WAIT && sync2_ff.init) begin
            mode_ff     <= sync2_ff.mode;
            mode_err_ff <= (sync2_ff.mode != MODE_MASTER_SERIAL);
         end else if (state_ff == ST_LOAD && nxt_state == ST_ERROR) begin
            crc_err_ff  <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Pin outputs. Open-drain lines only ever pull low.
   // -------------------------------------------------------------------
   pin_out_t nxt_pins;
   always_comb begin
      nxt_pins.config_clock_out = cfg_clk_ff;
      nxt_pins.data_out      = dout_ff;
      nxt_pins.init_out      = 1'b0;
      // Init low resets the memory; released it lets the memory drive data.
      nxt_pins.init_oe_n     = !(nxt_state == ST_IDLE || nxt_state == ST_CLEAR ||
                                 (nxt_state == ST_ERROR && (crc_err_ff ||
                                  (state_ff == ST_LOAD))));
      nxt_pins.done_out      = 1'b0;
      nxt_pins.done_oe_n     = (nxt_state == ST_DONE);
      nxt_pins.pullup_enable = (nxt_state != ST_DONE) && !sync2_ff.pullup_disable_pin;
      nxt_pins.mode_released = (nxt_state == ST_DONE);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_out_ff <= '{config_clock_out: 1'b0, data_out: 1'b1, init_out: 1'b0, init_oe_n: 1'b0,
                          done_out: 1'b0, done_oe_n: 1'b0, pullup_enable: 1'b0, mode_released: 1'b0};
      end else if (ce) begin
         pins_out_ff <= nxt_pins;
      end
   end
   assign pins_out = pins_out_ff;

   // -------------------------------------------------------------------
   // APB slave, one wait-free access phase.
   // -------------------------------------------------------------------
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   wire         setup   = psel && !penable;
   wire         wr_take = psel && penable && pready_ff && pwrite;
   wire         mapped  = (paddr == CTRL_OFF) || (paddr == STATUS_OFF) ||
                          (paddr == BITCNT_OFF) || (paddr == RATE_OFF);
   wire [31:0]  status_word = 32'({pins_out_ff.pullup_enable, (state_ff == ST_DONE), mode_err_ff,
                                   crc_err_ff, mode_ff, state_ff});
   wire [31:0]  rd_mux = (paddr == CTRL_OFF)   ? 32'({forward_en_ff, 1'b0}) :
                         (paddr == STATUS_OFF) ? status_word :
                         (paddr == BITCNT_OFF) ? 32'(bit_cnt_ff) :
                         (paddr == RATE_OFF)   ? 32'({half_ff}) : 32'h0000_0000;

   // Answer is prepared in the setup cycle and shown in the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !mapped;
         prdata_ff  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Control register; the reload bit is a self-clearing pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forward_en_ff  <= CTRL_FORWARD_RST;
         soft_reload_ff <= 1'b0;
      end else if (ce) begin
         soft_reload_ff <= wr_take && (paddr == CTRL_OFF) && pwdata[CTRL_RELOAD_BIT];
         if (wr_take && paddr == CTRL_OFF) forward_en_ff <= pwdata[CTRL_FORWARD_BIT];
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // -------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   sequence prog_held_s;
      prog_low [*8];
   endsequence

   // Pins and state load from the same next state, so they are compared in the same cycle.
   clear_holds_init_a: assert property ((state_ff == ST_CLEAR) |-> !pins_out_ff.init_oe_n)
      else $error("init line not pulled low while clearing");
   done_low_load_a: assert property ((state_ff == ST_LOAD) |-> !pins_out_ff.done_oe_n)
      else $error("completion line released during loading");
   done_release_a: assert property ((state_ff != ST_DONE && nxt_state == ST_DONE && !restart)
                                    |=> pins_out_ff.done_oe_n && pins_out_ff.mode_released)
      else $error("completion line not released after success");
   crc_err_init_a: assert property ((state_ff == ST_LOAD && nxt_state == ST_ERROR && !restart)
                                    |=> !pins_out_ff.init_oe_n [*2])
      else $error("CRC error did not pull init low");
   prog_restart_a: assert property ((prog_cnt_ff == 8'(PROG_MIN_CYC - 1) && prog_low)
                                    |=> ##1 state_ff == ST_IDLE)
      else $error("long program pulse did not restart loading");
   short_prog_a: assert property (prog_held_s |-> prog_cnt_ff >= 8'h06)
      else $error("program low time not counted");
   rise_capture_a: assert property (load_bit && !last_bit |=> bit_cnt_ff == $past(bit_cnt_ff) + 24'h000001)
      else $error("bit not taken on rising config clock");
   dout_drive_a: assert property ((state_ff == ST_LOAD) |-> dout_ff)
      else $error("data output not driven high during loading");
   pullup_ctrl_a: assert property ((state_ff == ST_LOAD && sync2_ff.pullup_disable_pin)
                                   |=> !pins_out_ff.pullup_enable)
      else $error("pull-ups enabled while disabled by pin");
   forward_fall_a: assert property ((state_ff == ST_DONE && fall && !restart)
                                    |=> dout_ff == $past(sync2_ff.data))
      else $error("data not forwarded on falling config clock");
   idle_wait_prog_a: assert property ((state_ff == ST_IDLE && prog_low) |=> state_ff == ST_IDLE)
      else $error("loading began with program input low");
endmodule
`default_nettype wire

// File: tb/cfg_memory.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Serial configuration memory with an address counter.
// ---------------------------------------------------------------
module cfg_memory #(
   parameter int unsigned N = 64
) (
   input  wire logic         clk_in,
   input  wire logic         reset_oe,
   input  wire logic         chip_en_n,
   input  wire logic [N-1:0] image,
   input  wire logic         prog_n,
   output logic              data,
   output logic              por_n,
   output logic              memory_configure_pin
);
   int   addr = 0;     // Index of the bit on show.
   logic last = 1'b0;  // Last driven bit; its inverse shows once released.
   wire  drive = reset_oe && !chip_en_n && (addr < N);
   // The power-on reset of the memory keeps the init line low for a while.
   initial begin
      por_n = 1'b0;
      #3000 por_n = 1'b1;
   end
   // Low reset input clears the counter; a selected memory steps after each rising edge.
   always @(posedge clk_in or negedge reset_oe) begin
      if (!reset_oe) addr <= 0;
      else if (!chip_en_n && addr < N) addr <= addr + 1;
   end
   always @* if (drive) last = image[N-1-addr];
   assign data = drive ? image[N-1-addr] : ~last;
   // The configure pin passes on a reprogramming request to the loader's program input.
   assign memory_configure_pin = prog_n;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Loader bench: APB tasks and a memory model on the pins.
// ---------------------------------------------------------------
module tb_top;
   import msl_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, last_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, pu_pin, prog_n, mem_d, por_n, cfg_pin;
   logic [2:0]  mode;
   logic [63:0] image;
   pin_in_t     pin_i;
   pin_out_t    pin_o;
   int          error_cnt, total_checks;
   // Open-drain lines: either party may pull init low, only the loader pulls done; pull-ups give high.
   wire init_line = pin_o.init_oe_n & por_n;
   wire done_line = pin_o.done_oe_n;
   assign pin_i = '{mode: mode, pullup_disable_pin: pu_pin, data: mem_d, init: init_line,
                    done: done_line, reload_request_n: cfg_pin};
   master_serial_config_loader #(.BITS_TOTAL(64)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pin_i), .pins_out(pin_o));
   cfg_memory #(.N(64)) mem (.clk_in(pin_o.config_clock_out), .reset_oe(init_line),
      .chip_en_n(done_line), .image(image), .prog_n(prog_n), .data(mem_d), .por_n(por_n),
      .memory_configure_pin(cfg_pin));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Rate byte, body, then CRC-16 over everything before it, MSB first.
   function automatic logic [63:0] mk_img(input logic [47:0] body);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ body[i]) ? 16'h1021 : 16'h0000);
      return {body, c};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r & m, exp);
   endtask
   task automatic wait_st(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0);
         n++;
      end while (r[2:0] !== s && n < 3000);
      chk({29'h0, r[2:0]}, {29'h0, s});
   endtask
   task automatic pulse();
      prog_n <= 1'b0;
      repeat (70) @(posedge pclk);
      rd(8'h04, 32'h7, 32'h0);
      prog_n <= 1'b1;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #300000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude();
   end
   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; mode = 3'h0; pu_pin = 1'b0; prog_n = 1'b1; error_cnt = 0; total_checks = 0;
      image = mk_img({8'h10, 40'hA53C960FE1});
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'hFFFFFFFF, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      chk({29'h0, pin_o.init_oe_n, pin_o.done_oe_n, pin_o.data_out}, 32'h1);
      wait_st(3'h3);
      wait_st(3'h2);
      chk({31'h0, pin_o.pullup_enable}, 32'h1);
      wait_st(3'h6);
      rd(8'h08, 32'hFFFFFFFF, 32'h40);
      rd(8'h0C, 32'hFF, 32'h10);
      chk({30'h0, pin_o.mode_released, pin_o.done_oe_n}, 32'h3);
      prog_n <= 1'b0;
      repeat (40) @(posedge pclk);
      prog_n <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(8'h04, 32'h7, 32'h6);
      pu_pin <= 1'b1;
      pulse();
      wait_st(3'h1);
      chk({30'h0, pin_o.init_oe_n, pin_o.done_oe_n}, 32'h0);
      wait_st(3'h2);
      chk({31'h0, pin_o.pullup_enable}, 32'h0);
      wait_st(3'h6);
      image <= image ^ (64'h1 << 20);
      apb(1'b1, 8'h00, 32'h3);
      wait_st(3'h7);
      rd(8'h04, 32'h40, 32'h40);
      chk({30'h0, pin_o.init_oe_n, pin_o.done_oe_n}, 32'h0);
      image <= mk_img({8'h10, 40'hA53C960FE1});
      mode <= 3'h1;
      pulse();
      wait_st(3'h7);
      rd(8'h04, 32'h80, 32'h80);
      chk({31'h0, pin_o.init_oe_n}, 32'h1);
      conclude();
   end
endmodule
`default_nettype wire
